// File: rtl/rtcc_pkg.sv
// constants, types and register map shared by the retimer channel control
package rtcc_pkg;

  // register offsets and fields
  localparam logic [7:0] LOCK_MON_CTRL_OFS = 8'h3e;
  localparam logic [7:0] TABLE_BASE_OFS    = 8'h40;
  localparam logic [7:0] TABLE_LAST_OFS    = 8'h5f;
  localparam int         LOCK_MON_EN_BIT   = 7;
  localparam logic [7:0] LOCK_MON_CTRL_RST = 8'h80;
  localparam logic [7:0] TABLE_ENTRY_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA    = 8'h00;

  // equalizer geometry
  localparam int TABLE_DEPTH = 32;
  localparam int STAGES      = 4;
  localparam int STAGE_W     = 2;
  localparam int LEVEL_W     = 4;

  // acquisition and calibration
  localparam int ACQ_ATTEMPTS  = 4;
  localparam int ADAPT_DWELL   = 64;
  localparam int CAL_REF_TICKS = 16;

  // timing, in milliseconds as given, and derived cycle counts
  localparam int MCLK_KHZ         = 200000;
  localparam int LOCK_QUAL_OFF_MS = 2;
  localparam int LOCK_QUAL_ON_MS  = 12;
  localparam int ACQ_ATTEMPT_MS   = 20;
  localparam int LOCK_QUAL_OFF_CYC = LOCK_QUAL_OFF_MS * MCLK_KHZ;
  localparam int LOCK_QUAL_ON_CYC  = LOCK_QUAL_ON_MS * MCLK_KHZ;
  localparam int ACQ_ATTEMPT_CYC   = ACQ_ATTEMPT_MS * MCLK_KHZ;

  typedef enum logic [2:0] {
    ST_CAL    = 3'b000,
    ST_IDLE   = 3'b001,
    ST_ADAPT  = 3'b010,
    ST_ACQ    = 3'b011,
    ST_LOCKED = 3'b100
  } rtcc_state_t;

  typedef struct packed {
    logic        manual;
    logic [15:0] ppm_count;
    logic [3:0]  div_ratio;
  } rtcc_cal_target_t;

  typedef struct packed {
    logic       locked;
    logic       adapting;
    logic       cal_busy;
    logic [2:0] attempts;
  } rtcc_status_t;

endpackage

// File: rtl/rtcc_channel_ctrl.sv
// retimer channel control: signal gating, equalizer adaptation, vco calibration, data fifo
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module rtcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     flush,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push_w = in_valid & in_ready;
  wire              pop_w  = out_valid & out_ready;

  assign level     = wr_ptr_reg - rd_ptr_reg;
  assign in_ready  = (level != DEPTH[AW:0]) & ~flush;
  assign out_valid = (level != '0) & ~flush;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wr_ptr_reg <= '0;
    else if (flush)
      wr_ptr_reg <= '0;
    else if (push_w)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rd_ptr_reg <= '0;
    else if (flush)
      rd_ptr_reg <= '0;
    else if (pop_w)
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
  end

  // storage needs no reset; empty flag guards it
  always_ff @(posedge mclk)
  begin
    if (push_w)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rtcc_channel_ctrl #(
  parameter int DATA_W         = 8,
  parameter int FIFO_DEPTH     = 8,
  parameter int CODE_W         = 6,
  parameter int LOCK_QUAL_OFF  = rtcc_pkg::LOCK_QUAL_OFF_CYC,
  parameter int LOCK_QUAL_ON   = rtcc_pkg::LOCK_QUAL_ON_CYC,
  parameter int ACQ_ATTEMPT    = rtcc_pkg::ACQ_ATTEMPT_CYC
) (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rstn,
  // register port
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  output logic [7:0]                        reg_rdata,
  // channel controls
  input  wire logic                         sd_override_en,
  input  wire logic                         sd_force_disable,
  input  wire logic                         stage4_limit_sel,
  input  wire logic                         readapt_cmd,
  input  wire logic                         cdr_reset,
  input  wire rtcc_pkg::rtcc_cal_target_t   cal_target,
  input  wire logic [15:0]                  rate_target_count,
  // analog front-end observations
  input  wire logic                         signal_present,
  input  wire logic                         cdr_lock,
  input  wire logic                         eye_open_ok,
  input  wire logic [7:0]                   adaptation_quality_score,
  input  wire logic                         ref_tick,
  input  wire logic                         vco_div_tick,
  // analog front-end controls
  output logic                              path_power_on,
  output logic [7:0]                        eq_stage_codes,
  output logic [3:0]                        eq_boost_level,
  output logic                              stage4_limiting,
  output logic [CODE_W-1:0]                 vco_coarse_code,
  output logic                              lock_monitor_en,
  output rtcc_pkg::rtcc_status_t            status,
  // recovered data stream
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [DATA_W-1:0]            in_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [DATA_W-1:0]                 out_data
);
  localparam int NUM_CODES = 1 << CODE_W;
  localparam int QW        = 24;
  localparam int FW        = $clog2(FIFO_DEPTH) + 1;

  rtcc_pkg::rtcc_state_t state_reg;
  rtcc_pkg::rtcc_state_t state_next;

  logic [7:0]        table_reg [rtcc_pkg::TABLE_DEPTH];
  logic [7:0]        lock_mon_reg;
  logic [7:0]        reg_rdata_reg;
  logic [4:0]        idx_reg;
  logic [4:0]        best_idx_reg;
  logic [7:0]        best_score_reg;
  logic [7:0]        dwell_reg;
  logic [7:0]        eq_codes_reg;
  logic [3:0]        eq_level_reg;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] best_code_reg;
  logic [CODE_W-1:0] vco_code_reg;
  logic [15:0]       best_diff_reg;
  logic [7:0]        ref_cnt_reg;
  logic [15:0]       vco_cnt_reg;
  logic [3:0]        pre_cnt_reg;
  logic [2:0]        attempts_reg;
  logic [QW-1:0]     qual_reg;
  logic [QW-1:0]     attempt_reg;
  logic              path_on_reg;
  logic              limit_reg;
  logic              in_ready_reg;
  logic              out_valid_reg;
  logic [DATA_W-1:0] out_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire       in_table_w = (reg_addr >= rtcc_pkg::TABLE_BASE_OFS) && (reg_addr <= rtcc_pkg::TABLE_LAST_OFS);
  wire [4:0] tbl_sel_w  = 5'(reg_addr - rtcc_pkg::TABLE_BASE_OFS);
  wire       mon_hit_w  = (reg_addr == rtcc_pkg::LOCK_MON_CTRL_OFS);
  wire       mon_en_w   = lock_mon_reg[rtcc_pkg::LOCK_MON_EN_BIT];
  wire [7:0] rd_mux_w   = mon_hit_w  ? lock_mon_reg :
                          in_table_w ? table_reg[tbl_sel_w] : rtcc_pkg::UNMAPPED_RDATA;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      lock_mon_reg <= rtcc_pkg::LOCK_MON_CTRL_RST;
    else if (reg_wr && mon_hit_w)
      lock_mon_reg <= reg_wdata;
  end

  genvar gi;
  generate
    for (gi = 0; gi < rtcc_pkg::TABLE_DEPTH; gi++)
    begin : g_table
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          table_reg[gi] <= rtcc_pkg::TABLE_ENTRY_RST;
        else if (reg_wr && in_table_w && (tbl_sel_w == 5'(gi)))
          table_reg[gi] <= reg_wdata;
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_reg <= '0;
    else if (reg_rd)
      reg_rdata_reg <= rd_mux_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // signal detect gating
  wire path_on_w = sd_override_en ? ~sd_force_disable : signal_present;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      path_on_reg <= 1'b0;
      limit_reg   <= 1'b0;
    end
    else
    begin
      path_on_reg <= path_on_w;
      limit_reg   <= stage4_limit_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // adaptation sweep
  wire       dwell_end_w  = (state_reg == rtcc_pkg::ST_ADAPT) && (dwell_reg == 8'(rtcc_pkg::ADAPT_DWELL - 1));
  wire       better_w     = (idx_reg == '0) || (adaptation_quality_score > best_score_reg);
  wire [4:0] best_pick_w  = better_w ? idx_reg : best_idx_reg;
  wire       adapt_done_w = dwell_end_w && (idx_reg == 5'(rtcc_pkg::TABLE_DEPTH - 1));
  wire       enter_adapt_w = (state_next == rtcc_pkg::ST_ADAPT) && (state_reg != rtcc_pkg::ST_ADAPT);

  // per-stage sum gives the effective boost level
  logic [3:0] level_w;
  logic [7:0] codes_next;
  always_comb
  begin
    codes_next = eq_codes_reg;
    if (enter_adapt_w)
      codes_next = table_reg[0];
    else if (adapt_done_w)
      codes_next = table_reg[best_pick_w];
    else if (dwell_end_w)
      codes_next = table_reg[5'(idx_reg + 1'b1)];
    level_w = '0;
    for (int s = 0; s < rtcc_pkg::STAGES; s++)
      level_w = level_w + 4'(codes_next[s*rtcc_pkg::STAGE_W +: rtcc_pkg::STAGE_W]);
  end

  // codes only move while adapting, so lock freezes them
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      eq_codes_reg <= '0;
      eq_level_reg <= '0;
    end
    else
    begin
      eq_codes_reg <= codes_next;
      eq_level_reg <= level_w;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_reg        <= '0;
      dwell_reg      <= '0;
      best_idx_reg   <= '0;
      best_score_reg <= '0;
    end
    else if (enter_adapt_w)
    begin
      idx_reg   <= '0;
      dwell_reg <= '0;
    end
    else if (dwell_end_w)
    begin
      idx_reg        <= 5'(idx_reg + 1'b1);
      dwell_reg      <= '0;
      best_idx_reg   <= best_pick_w;
      best_score_reg <= better_w ? adaptation_quality_score : best_score_reg;
    end
    else if (state_reg == rtcc_pkg::ST_ADAPT)
      dwell_reg <= 8'(dwell_reg + 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // vco coarse calibration
  wire [15:0] target_w  = cal_target.manual ? cal_target.ppm_count : rate_target_count;
  wire [3:0]  div_w     = cal_target.manual ? cal_target.div_ratio : 4'h0;
  wire        in_cal_w  = (state_reg == rtcc_pkg::ST_CAL);
  wire        meas_end_w = in_cal_w && ref_tick && (ref_cnt_reg == 8'(rtcc_pkg::CAL_REF_TICKS - 1));
  wire [15:0] diff_w    = (vco_cnt_reg > target_w) ? (vco_cnt_reg - target_w) : (target_w - vco_cnt_reg);
  wire        closer_w  = (code_reg == '0) || (diff_w < best_diff_reg);
  wire        cal_done_w = meas_end_w && (code_reg == CODE_W'(NUM_CODES - 1));
  wire        enter_cal_w = (state_next == rtcc_pkg::ST_CAL) && ((state_reg != rtcc_pkg::ST_CAL) || cdr_reset);
  wire        pre_wrap_w = vco_div_tick && (pre_cnt_reg == div_w);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_cnt_reg <= '0;
      vco_cnt_reg <= '0;
      pre_cnt_reg <= '0;
    end
    else if (enter_cal_w || meas_end_w)
    begin
      ref_cnt_reg <= '0;
      vco_cnt_reg <= '0;
      pre_cnt_reg <= '0;
    end
    else if (in_cal_w)
    begin
      if (ref_tick)
        ref_cnt_reg <= 8'(ref_cnt_reg + 1'b1);
      if (vco_div_tick)
        pre_cnt_reg <= pre_wrap_w ? 4'h0 : 4'(pre_cnt_reg + 1'b1);
      if (pre_wrap_w)
        vco_cnt_reg <= 16'(vco_cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      code_reg      <= '0;
      best_code_reg <= '0;
      best_diff_reg <= '0;
      vco_code_reg  <= '0;
    end
    else if (enter_cal_w)
    begin
      code_reg     <= '0;
      vco_code_reg <= '0;
    end
    else if (meas_end_w)
    begin
      code_reg      <= CODE_W'(code_reg + 1'b1);
      best_code_reg <= closer_w ? code_reg : best_code_reg;
      best_diff_reg <= closer_w ? diff_w : best_diff_reg;
      vco_code_reg  <= cal_done_w ? (closer_w ? code_reg : best_code_reg) : CODE_W'(code_reg + 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock acquisition
  wire          in_acq_w    = (state_reg == rtcc_pkg::ST_ACQ);
  wire          qualify_w   = cdr_lock && (!mon_en_w || eye_open_ok);
  wire [QW-1:0] qual_tgt_w  = mon_en_w ? QW'(LOCK_QUAL_ON - 1) : QW'(LOCK_QUAL_OFF - 1);
  wire          qual_done_w = in_acq_w && qualify_w && (qual_reg >= qual_tgt_w);
  wire          attempt_end_w = in_acq_w && (attempt_reg == QW'(ACQ_ATTEMPT - 1));
  wire          last_try_w  = (attempts_reg == 3'(rtcc_pkg::ACQ_ATTEMPTS - 1));

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      qual_reg    <= '0;
      attempt_reg <= '0;
    end
    else
    begin
      qual_reg    <= (in_acq_w && qualify_w && !qual_done_w) ? QW'(qual_reg + 1'b1) : '0;
      attempt_reg <= (in_acq_w && !attempt_end_w && state_next == rtcc_pkg::ST_ACQ) ? QW'(attempt_reg + 1'b1) : '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      attempts_reg <= '0;
    else if (enter_cal_w || qual_done_w)
      attempts_reg <= '0;
    else if (attempt_end_w)
      attempts_reg <= 3'(attempts_reg + 1'b1);
  end

  // channel sequencer; a cdr reset outranks everything
  always_comb
  begin
    state_next = state_reg;
    if (cdr_reset)
      state_next = rtcc_pkg::ST_CAL;
    else
      case (state_reg)
        rtcc_pkg::ST_CAL:
          if (cal_done_w)
            state_next = rtcc_pkg::ST_IDLE;
        rtcc_pkg::ST_IDLE:
          if (path_on_w)
            state_next = rtcc_pkg::ST_ADAPT;
        rtcc_pkg::ST_ADAPT:
          if (!path_on_w)
            state_next = rtcc_pkg::ST_IDLE;
          else if (adapt_done_w)
            state_next = rtcc_pkg::ST_ACQ;
        rtcc_pkg::ST_ACQ:
          if (!path_on_w)
            state_next = rtcc_pkg::ST_IDLE;
          else if (readapt_cmd)
            state_next = rtcc_pkg::ST_ADAPT;
          else if (qual_done_w)
            state_next = rtcc_pkg::ST_LOCKED;
          else if (attempt_end_w && last_try_w)
            state_next = rtcc_pkg::ST_CAL;
        rtcc_pkg::ST_LOCKED:
          if (!path_on_w)
            state_next = rtcc_pkg::ST_IDLE;
          else if (!cdr_lock || readapt_cmd)
            state_next = rtcc_pkg::ST_ADAPT;
        default:
          state_next = rtcc_pkg::ST_CAL;
      endcase
  end

  // reset lands in calibration, which is the power-up run
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= rtcc_pkg::ST_CAL;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data path; no state is shared with other channels
  wire              gate_w = path_on_w && (state_next == rtcc_pkg::ST_LOCKED);
  wire              f_in_ready;
  wire              f_out_valid;
  wire [DATA_W-1:0] f_out_data;
  wire [FW-1:0]     f_level;
  wire              f_out_ready = ~out_valid_reg | out_ready;

  rtcc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (~path_on_reg),
    .in_valid  (in_valid & in_ready_reg),
    .in_ready  (f_in_ready),
    .in_data   (in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // registered ready leaves one slot of slack for the push in flight
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      in_ready_reg <= 1'b0;
    else
      in_ready_reg <= gate_w && f_in_ready && (f_level <= FW'(FIFO_DEPTH - 2));
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (!path_on_reg)
      out_valid_reg <= 1'b0;
    else if (f_out_ready)
    begin
      out_valid_reg <= f_out_valid;
      out_data_reg  <= f_out_valid ? f_out_data : out_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata       = reg_rdata_reg;
  assign path_power_on   = path_on_reg;
  assign eq_stage_codes  = eq_codes_reg;
  assign eq_boost_level  = eq_level_reg;
  assign stage4_limiting = limit_reg;
  assign vco_coarse_code = vco_code_reg;
  assign lock_monitor_en = lock_mon_reg[rtcc_pkg::LOCK_MON_EN_BIT];
  assign status.locked   = (state_reg == rtcc_pkg::ST_LOCKED);
  assign status.adapting = (state_reg == rtcc_pkg::ST_ADAPT);
  assign status.cal_busy = in_cal_w;
  assign status.attempts = attempts_reg;
  assign in_ready        = in_ready_reg;
  assign out_valid       = out_valid_reg;
  assign out_data        = out_data_reg;
endmodule

// File: tb/rtcc_channel_ctrl_props.sv
// concurrent checks on the channel control ports
`timescale 1ns/100ps
module rtcc_channel_ctrl_chk #(
  parameter int CODE_W = 6
) (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rstn,
  // register port
  input wire logic                   reg_wr,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  // controls and observations
  input wire logic                   sd_override_en,
  input wire logic                   sd_force_disable,
  input wire logic                   readapt_cmd,
  input wire logic                   cdr_reset,
  input wire logic                   signal_present,
  input wire logic                   cdr_lock,
  // outputs
  input wire logic                   path_power_on,
  input wire logic [7:0]             eq_stage_codes,
  input wire logic [3:0]             eq_boost_level,
  input wire logic [CODE_W-1:0]      vco_coarse_code,
  input wire logic                   lock_monitor_en,
  input wire rtcc_pkg::rtcc_status_t status,
  input wire logic                   in_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // path stays on, no reset: lock path decides
  wire       hold = path_power_on && signal_present && !sd_override_en && !cdr_reset;
  wire [3:0] lsum = 4'(eq_stage_codes[1:0]) + 4'(eq_stage_codes[3:2]) + 4'(eq_stage_codes[5:4])
                    + 4'(eq_stage_codes[7:6]);
  ////////////////////////////////////////////////////////////////////////////////
  property p_sd_auto; !sd_override_en |=> path_power_on == $past(signal_present); endproperty
  a_sd_auto: assert property (p_sd_auto) else $error("path power not following signal");
  property p_sd_force; sd_override_en |=> path_power_on == !$past(sd_force_disable); endproperty
  a_sd_force: assert property (p_sd_force) else $error("override ignored");
  property p_freeze; !status.adapting && !$past(status.adapting) |-> $stable(eq_stage_codes); endproperty
  a_freeze: assert property (p_freeze) else $error("boost moved outside adaptation");
  property p_relock; status.locked && (readapt_cmd || !cdr_lock) && hold |=> status.adapting; endproperty
  a_relock: assert property (p_relock) else $error("no readaptation from lock");
  property p_sum; eq_boost_level == lsum; endproperty
  a_sum: assert property (p_sum) else $error("boost level not stage sum");
  property p_mon_wr; reg_wr && reg_addr == 8'h3e |=> lock_monitor_en == $past(reg_wdata[7]); endproperty
  a_mon_wr: assert property (p_mon_wr) else $error("monitor enable not written");
  property p_cal_trig; cdr_reset |=> status.cal_busy; endproperty
  a_cal_trig: assert property (p_cal_trig) else $error("cdr reset did not calibrate");
  property p_vco_hold; !status.cal_busy && !$past(status.cal_busy) |-> $stable(vco_coarse_code); endproperty
  a_vco_hold: assert property (p_vco_hold) else $error("coarse code moved");
  property p_tries; status.locked || status.cal_busy |-> status.attempts == 3'h0; endproperty
  a_tries: assert property (p_tries) else $error("attempt count not cleared");
  property p_flow; in_ready |-> status.locked && path_power_on; endproperty
  a_flow: assert property (p_flow) else $error("data accepted before lock");
  c_lock: cover property ($rose(status.locked));
  c_adapt: cover property ($rose(status.adapting));
  c_cal: cover property ($rose(status.cal_busy));
endmodule

bind rtcc_channel_ctrl rtcc_channel_ctrl_chk #(.CODE_W(CODE_W)) u_chk (
  .mclk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .sd_override_en, .sd_force_disable, .readapt_cmd,
  .cdr_reset, .signal_present, .cdr_lock, .path_power_on, .eq_stage_codes, .eq_boost_level,
  .vco_coarse_code, .lock_monitor_en, .status, .in_ready
);

// File: tb/rtcc_far_model.sv
// far side: transmitter over a lossy channel plus the analog front end of one channel
`timescale 1ns/100ps
module rtcc_far_model #(
  parameter int CODE_W     = 6,
  parameter int MATCH_CODE = 20
) (
  // clock and scenario controls
  input wire logic              mclk,
  input wire logic              live,
  input wire logic              lock_ok,
  // from the channel
  input wire logic [7:0]        eq_stage_codes,
  input wire logic [CODE_W-1:0] vco_coarse_code,
  // to the channel
  output logic                  signal_present,
  output logic                  cdr_lock,
  output logic                  eye_open_ok,
  output logic [7:0]            adaptation_quality_score,
  output logic                  ref_tick,
  output logic                  vco_div_tick
);
  logic [2:0] ref_div;

  initial
  begin
    {ref_div, signal_present, cdr_lock, eye_open_ok, adaptation_quality_score} = '0;
    {ref_tick, vco_div_tick} = '0;
  end

  always @(negedge mclk)
  begin
    ref_div <= ref_div + 3'h1;
    ref_tick <= (ref_div == 3'h7); // one reference edge per 8 cycles
    // one code only hits, so the search is unambiguous
    vco_div_tick <= (vco_coarse_code == CODE_W'(MATCH_CODE));
    signal_present <= live;
    cdr_lock <= live && lock_ok;
    eye_open_ok <= live && lock_ok;
    adaptation_quality_score <= (eq_stage_codes == 8'h5a) ? 8'hc8 : eq_stage_codes;
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for one retimer channel control instance
`timescale 1ns/100ps
module tb_top;
  localparam int MATCH = 20;
  logic                       mclk, rstn, reg_wr, reg_rd, sd_override_en, sd_force_disable, took;
  logic                       stage4_limit_sel, readapt_cmd, cdr_reset, signal_present, cdr_lock;
  logic                       eye_open_ok, ref_tick, vco_div_tick, path_power_on, stage4_limiting;
  logic                       lock_monitor_en, in_valid, in_ready, out_valid, out_ready, live, lock_ok;
  logic [7:0]                 reg_addr, reg_wdata, reg_rdata, adaptation_quality_score;
  logic [7:0]                 eq_stage_codes, in_data, out_data;
  logic [3:0]                 eq_boost_level;
  logic [5:0]                 vco_coarse_code;
  logic [15:0]                rate_target_count;
  rtcc_pkg::rtcc_cal_target_t cal_target;
  rtcc_pkg::rtcc_status_t     status;
  int                         err_total, compares, n, j;

  rtcc_channel_ctrl #(.LOCK_QUAL_OFF(20), .LOCK_QUAL_ON(40), .ACQ_ATTEMPT(200)) u_dut (
    .mclk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sd_override_en,
    .sd_force_disable, .stage4_limit_sel, .readapt_cmd, .cdr_reset, .cal_target, .rate_target_count,
    .signal_present, .cdr_lock, .eye_open_ok, .adaptation_quality_score, .ref_tick, .vco_div_tick,
    .path_power_on, .eq_stage_codes, .eq_boost_level, .stage4_limiting, .vco_coarse_code,
    .lock_monitor_en, .status, .in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data
  );
  rtcc_far_model #(.MATCH_CODE(MATCH)) u_far (
    .mclk, .live, .lock_ok, .eq_stage_codes, .vco_coarse_code, .signal_present, .cdr_lock,
    .eye_open_ok, .adaptation_quality_score, .ref_tick, .vco_div_tick
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // quiet cycle after a strobe: no double drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    chk("rdata", 16'(reg_rdata), 16'(e));
  endtask

  function automatic logic st(input int k);
    return k == 0 ? status.cal_busy : k == 1 ? status.adapting : status.locked;
  endfunction

  task automatic wt(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && st(k) !== v; i++)
      @(negedge mclk);
    if (i == lim)
    begin
      err_total++;
      $display("BAD wait %0d expected %b seen %b", k, v, st(k));
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, reg_wr, reg_rd, sd_override_en, sd_force_disable, stage4_limit_sel, readapt_cmd} = '0;
    {cdr_reset, in_valid, out_ready, live, lock_ok, reg_addr, reg_wdata, in_data} = '0;
    {err_total, compares} = '0;
    cal_target = '0;
    rate_target_count = 16'h0080;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk("mon_en", 16'(lock_monitor_en), 16'h0001);
    chk("cal", 16'(status.cal_busy), 16'h0001);
    rdc(8'h3e, 8'h80);
    rdc(8'h40, 8'h00);
    for (n = 0; n < 32; n++)
      wr(8'h40 + 8'(n), n == 17 ? 8'h5a : 8'(n));
    rdc(8'h5f, 8'h1f);
    rdc(8'h51, 8'h5a);
    wr(8'h60, 8'hff);
    rdc(8'h60, 8'h00);
    wr(8'h3e, 8'h00);
    chk("mon_en", 16'(lock_monitor_en), 16'h0000);
    wr(8'h3e, 8'h80);
    wt(0, 1'b0, 10000);
    chk("vco", 16'(vco_coarse_code), 16'(MATCH));
    chk("path", 16'(path_power_on), 16'h0000);
    live = 1'b1;
    wt(1, 1'b1, 5);
    chk("path", 16'(path_power_on), 16'h0001);
    wt(1, 1'b0, 2100);
    chk("codes", 16'(eq_stage_codes), 16'h005a);
    chk("level", 16'(eq_boost_level), 16'h0006);
    lock_ok = 1'b1;
    wt(2, 1'b1, 60);
    chk("tries", 16'(status.attempts), 16'h0000);
    // fill with drain stalled
    in_valid = 1'b1;
    n = 0;
    repeat (20)
    begin
      in_data = 8'h30 + 8'(n);
      took = in_ready;
      @(negedge mclk);
      if (took === 1'b1)
        n++;
    end
    in_valid = 1'b0;
    chk("full", 16'(in_ready), 16'h0000);
    out_ready = 1'b1;
    j = 0;
    repeat (30)
    begin
      if (out_valid === 1'b1)
      begin
        chk("data", 16'(out_data), 16'(8'h30 + 8'(j)));
        j++;
      end
      @(negedge mclk);
    end
    chk("count", 16'(j), 16'(n));
    stage4_limit_sel = 1'b1;
    repeat (2) @(negedge mclk);
    chk("limit", 16'(stage4_limiting), 16'h0001);
    lock_ok = 1'b0;
    wt(1, 1'b1, 5);
    lock_ok = 1'b1;
    wt(2, 1'b1, 2200);
    readapt_cmd = 1'b1;
    wt(1, 1'b1, 5);
    readapt_cmd = 1'b0;
    lock_ok = 1'b0;
    wt(0, 1'b1, 3200);
    chk("tries", 16'(status.attempts), 16'h0000);
    wt(0, 1'b0, 10000);
    sd_override_en = 1'b1;
    sd_force_disable = 1'b1;
    repeat (2) @(negedge mclk);
    chk("path", 16'(path_power_on), 16'h0000);
    cal_target = {1'b1, 16'h0020, 4'h1};
    rate_target_count = '0;
    cdr_reset = 1'b1;
    @(negedge mclk);
    cdr_reset = 1'b0;
    chk("cal", 16'(status.cal_busy), 16'h0001);
    wt(0, 1'b0, 10000);
    chk("vco", 16'(vco_coarse_code), 16'(MATCH));
    stop_test();
  end
endmodule
